// ==== pmr_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmr_flash_model
    import pmr_pkg::*;
(
    // request from the reader and word back
    input wire logic                          clk,
    input wire logic                          flash_rd_req,
    input wire logic [pmr_pkg::PMR_ADDR_W-1:0] flash_rd_addr,
    output logic [pmr_pkg::PMR_WORD_W-1:0]    flash_rd_word
);
    // word is a marker bit over the address; toggles when not answering
    always_ff @(posedge clk)
        flash_rd_word <= flash_rd_req ? {1'b1, flash_rd_addr} : ~flash_rd_word;
endmodule : pmr_flash_model
`default_nettype wire

// ==== pmr_pkg.sv ====
package pmr_pkg;
    // program memory geometry: 8K words of 14 bits
    localparam int PMR_ADDR_W = 13;
    localparam int PMR_WORD_W = 14;
    localparam int PMR_HI_W   = PMR_WORD_W - 8;
    // register field positions and reset values
    localparam int PMR_CTL_RD_BIT = 0;
    localparam logic [7:0] PMR_RST_BYTE = 8'h00;
    // flash access length in instruction cycles
    localparam int PMR_ACCESS_CYC = 2;
    // sfr write selects from the core
    typedef enum logic [2:0] {
        PMR_SEL_NONE, PMR_SEL_ADDR_LO, PMR_SEL_ADDR_HI, PMR_SEL_CTL
    } pmr_sel_e;
endpackage : pmr_pkg

// ==== pmr_read_ctrl.sv ====
// Notes on behaviour
// - program memory reads work during normal run, no special mode needed
// - read address is the low five bits of the high address byte concatenated above the low address byte
// - software sets the read-start bit; the flash access starts from it
// - the flash access takes two instruction cycles after the bit is set
// - the second instruction after the start write is discarded by the core
// - fetched word lands in data pair: upper bits high, low byte low
// - code protection does not block or alter these reads
`timescale 1ns/1ps
`default_nettype none
module pmr_read_ctrl
    import pmr_pkg::*;
(
    // clock and reset (one tick per instruction cycle)
    input  wire logic                    clk,
    input  wire logic                    rstn,
    // sfr writes from the core
    input  wire pmr_pkg::pmr_sel_e       sfr_wr_sel,
    input  wire logic [7:0]              sfr_wr_data,
    // flash array port, word returned the cycle after the request
    output logic                         flash_rd_req,
    output logic [pmr_pkg::PMR_ADDR_W-1:0] flash_rd_addr,
    input  wire logic [pmr_pkg::PMR_WORD_W-1:0] flash_rd_word,
    // code protection setting, has no effect on this path
    input  wire logic                    code_protect,
    // register views to the core
    output logic [7:0]                   progmem_addr_low,
    output logic [7:0]                   progmem_addr_high,
    output logic [7:0]                   progmem_read_control,
    output logic [7:0]                   progmem_data_low,
    output logic [7:0]                   progmem_data_high,
    // tells the core which instruction slot to discard
    output logic                         core_slot_discard
);
    import pmr_pkg::*;

    // sequencer states: idle, then one state per access cycle
    typedef enum logic [1:0] {PMR_IDLE, PMR_ACC1, PMR_ACC2} pmr_state_e;

    // sequencer
    pmr_state_e                  state_r;
    pmr_state_e                  state_nxt;
    // read-start bit of the control register
    logic                        rd_r;
    logic                        rd_nxt;
    // address pair
    logic [7:0]                  addr_lo_r;
    logic [7:0]                  addr_lo_nxt;
    logic [7:0]                  addr_hi_r;
    logic [7:0]                  addr_hi_nxt;
    // data pair
    logic [7:0]                  dat_lo_r;
    logic [7:0]                  dat_lo_nxt;
    logic [7:0]                  dat_hi_r;
    logic [7:0]                  dat_hi_nxt;
    // flash port and core slot control
    logic                        req_r;
    logic [PMR_ADDR_W-1:0]       fl_addr_r;
    logic [PMR_ADDR_W-1:0]       fl_addr_nxt;
    logic                        discard_r;

    // sequencer position
    wire idle       = (state_r == PMR_IDLE);
    wire in_acc1    = (state_r == PMR_ACC1);
    wire capture    = (state_r == PMR_ACC2);

    // decode of core writes
    wire wr_addr_lo = (sfr_wr_sel == PMR_SEL_ADDR_LO);
    wire wr_addr_hi = (sfr_wr_sel == PMR_SEL_ADDR_HI);
    wire wr_ctl     = (sfr_wr_sel == PMR_SEL_CTL);
    // start bit, taken only while idle
    wire start      = wr_ctl && sfr_wr_data[PMR_CTL_RD_BIT] && idle;
    // address writes are refused mid-read so the latched location stays coherent
    wire addr_lo_we = wr_addr_lo && idle;
    wire addr_hi_we = wr_addr_hi && idle;
    wire unused_cp  = code_protect;

    wire [PMR_ADDR_W-1:0] rd_addr_cat = {addr_hi_r[PMR_ADDR_W-9:0], addr_lo_r};
    // word split, upper bits zero padded
    wire [7:0] word_lo = flash_rd_word[7:0];
    wire [7:0] word_hi = {{(8-PMR_HI_W){1'h0}}, flash_rd_word[PMR_WORD_W-1:8]};

    // sequence: idle, two access cycles, no mode gating
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            PMR_IDLE:
            begin
                if (start)
                    state_nxt = PMR_ACC1;
            end
            PMR_ACC1: state_nxt = PMR_ACC2;
            PMR_ACC2: state_nxt = PMR_IDLE;
            // the fourth code is unused; fall back to idle
            default:  state_nxt = PMR_IDLE;
        endcase
    end

    always_comb
    begin
        rd_nxt = rd_r;
        if (start)
            rd_nxt = 1'h1;
        else if (capture)
            rd_nxt = 1'h0;
    end

    // next address bytes, held while busy
    always_comb
    begin
        addr_lo_nxt = addr_lo_r;
        addr_hi_nxt = addr_hi_r;
        if (addr_lo_we)
            addr_lo_nxt = sfr_wr_data;
        if (addr_hi_we)
            addr_hi_nxt = sfr_wr_data;
    end

    always_comb
    begin
        fl_addr_nxt = fl_addr_r;
        if (start)
            fl_addr_nxt = rd_addr_cat;
    end

    always_comb
    begin
        dat_lo_nxt = dat_lo_r;
        dat_hi_nxt = dat_hi_r;
        if (capture)
        begin
            dat_lo_nxt = word_lo;
            dat_hi_nxt = word_hi;
        end
    end

    // sequencer state
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_r <= PMR_IDLE;
        else
            state_r <= state_nxt;
    end

    // read-start bit
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rd_r <= 1'h0;
        else
            rd_r <= rd_nxt;
    end

    // address pair, frozen while a read runs
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            addr_lo_r <= PMR_RST_BYTE;
            addr_hi_r <= PMR_RST_BYTE;
        end
        else
        begin
            addr_lo_r <= addr_lo_nxt;
            addr_hi_r <= addr_hi_nxt;
        end
    end

    // flash request in first access cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            req_r <= 1'h0;
        else
            req_r <= start;
    end

    // discard pulse on the second slot
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            discard_r <= 1'h0;
        else
            discard_r <= in_acc1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            fl_addr_r <= '0;
        else
            fl_addr_r <= fl_addr_nxt;
    end

    // data pair load, upper bits high
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dat_lo_r <= PMR_RST_BYTE;
            dat_hi_r <= PMR_RST_BYTE;
        end
        else
        begin
            dat_lo_r <= dat_lo_nxt;
            dat_hi_r <= dat_hi_nxt;
        end
    end

    // register views, all straight from flip-flops
    assign flash_rd_req         = req_r;
    assign flash_rd_addr        = fl_addr_r;
    assign core_slot_discard    = discard_r;
    assign progmem_addr_low     = addr_lo_r;
    assign progmem_addr_high    = addr_hi_r;
    // only the start bit is implemented; the rest read as zero
    assign progmem_read_control = {7'h00, rd_r};
    assign progmem_data_low     = dat_lo_r;
    assign progmem_data_high    = dat_hi_r;
endmodule : pmr_read_ctrl
`default_nettype wire

// ==== pmr_read_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module pmr_read_ctrl_asserts
    import pmr_pkg::*;
(
    // watched ports of the reader
    input wire logic                          clk,
    input wire logic                          rstn,
    input wire pmr_pkg::pmr_sel_e             sfr_wr_sel,
    input wire logic [7:0]                    sfr_wr_data,
    input wire logic                          flash_rd_req,
    input wire logic [pmr_pkg::PMR_ADDR_W-1:0] flash_rd_addr,
    input wire logic [pmr_pkg::PMR_WORD_W-1:0] flash_rd_word,
    input wire logic                          code_protect,
    input wire logic [7:0]                    progmem_addr_low,
    input wire logic [7:0]                    progmem_addr_high,
    input wire logic [7:0]                    progmem_read_control,
    input wire logic [7:0]                    progmem_data_low,
    input wire logic [7:0]                    progmem_data_high,
    input wire logic                          core_slot_discard
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // start accepted while idle, and the one-cycle discard pulse
    sequence s_start; sfr_wr_sel == PMR_SEL_CTL && sfr_wr_data[0] && !progmem_read_control[0]; endsequence
    sequence s_pulse; core_slot_discard ##1 !core_slot_discard; endsequence
    start_req_a: assert property (s_start |=> flash_rd_req)
        else $error("no flash request after start");
    addr_cat_a: assert property (flash_rd_req |-> flash_rd_addr == {progmem_addr_high[4:0], progmem_addr_low})
        else $error("flash address is not high:low");
    busy_two_a: assert property ($rose(progmem_read_control[0]) |-> progmem_read_control[0] [*2] ##1 !progmem_read_control[0])
        else $error("access not two cycles");
    slot_drop_a: assert property (flash_rd_req |=> s_pulse)
        else $error("second slot not discarded");
    data_load_a: assert property (core_slot_discard |=> {progmem_data_high, progmem_data_low} == {2'h0, $past(flash_rd_word)})
        else $error("data pair wrong");
    done_clear_a: assert property (core_slot_discard |=> progmem_read_control == 8'h00)
        else $error("start bit not cleared");
    req_cause_a: assert property (flash_rd_req |-> $past(sfr_wr_sel) == PMR_SEL_CTL)
        else $error("request without start write");
    prot_free_a: assert property (s_start ##0 code_protect |=> flash_rd_req ##1 core_slot_discard)
        else $error("protected read blocked");
endmodule : pmr_read_ctrl_asserts
bind pmr_read_ctrl pmr_read_ctrl_asserts chk_inst (.*);
`default_nettype wire

// ==== tb_pmr_read_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; $display("BAD %0t mismatch", $time); end end
module tb_pmr_read_ctrl;
    import pmr_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, code_protect = 1'b1, flash_rd_req, core_slot_discard;
    pmr_sel_e sfr_wr_sel = PMR_SEL_NONE;
    logic [7:0] sfr_wr_data = 8'h00, progmem_addr_low, progmem_addr_high, progmem_read_control;
    logic [7:0] progmem_data_low, progmem_data_high;
    logic [PMR_ADDR_W-1:0] flash_rd_addr;
    logic [PMR_WORD_W-1:0] flash_rd_word;
    int err_total = 0, total_checks = 0;
    pmr_read_ctrl pmr_read_ctrl_inst (.clk, .rstn, .sfr_wr_sel, .sfr_wr_data, .flash_rd_req,
        .flash_rd_addr, .flash_rd_word, .code_protect, .progmem_addr_low, .progmem_addr_high,
        .progmem_read_control, .progmem_data_low, .progmem_data_high, .core_slot_discard);
    pmr_flash_model pmr_flash_model_inst (.clk, .flash_rd_req, .flash_rd_addr, .flash_rd_word);
    initial forever #5 clk = ~clk;
    // one register write, held for one clock edge
    task automatic wr(input pmr_sel_e s, input logic [7:0] d);
        @(negedge clk);
        sfr_wr_sel = s;
        sfr_wr_data = d;
        @(negedge clk);
        sfr_wr_sel = PMR_SEL_NONE;
    endtask : wr
    // full read with both following slots left idle
    task automatic sc_read(input logic [7:0] hi, input logic [7:0] lo, input logic cp);
        code_protect = cp;
        wr(PMR_SEL_ADDR_HI, hi);
        wr(PMR_SEL_ADDR_LO, lo);
        wr(PMR_SEL_CTL, 8'h01);
        // both following slots left as no-operations
        `CHK(flash_rd_addr, {hi[4:0], lo})
        `CHK(progmem_addr_high, hi)
        `CHK(flash_rd_req, 1'b1)
        `CHK(progmem_read_control, 8'h01)
        `CHK(core_slot_discard, 1'b0)
        @(negedge clk);
        `CHK(core_slot_discard, 1'b1)
        `CHK(flash_rd_req, 1'b0)
        @(negedge clk);
        `CHK(progmem_data_low, lo)
        `CHK(progmem_data_high, {3'h1, hi[4:0]})
        `CHK(progmem_read_control, 8'h00)
    endtask : sc_read
    // address write while busy is ignored, read still completes
    task automatic sc_busy;
        wr(PMR_SEL_CTL, 8'h01);
        wr(PMR_SEL_ADDR_LO, 8'h00);
        `CHK(progmem_addr_low, 8'hFF)
        `CHK(progmem_data_low, 8'hFF)
        `CHK(progmem_read_control, 8'h00)
    endtask : sc_busy
    // verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        sc_read(8'h1F, 8'hFF, 1'b1);
        sc_busy;
        sc_read(8'h00, 8'h01, 1'b0);
        tally_and_finish;
    end
endmodule : tb_pmr_read_ctrl
`default_nettype wire
